/* rtl/spsc_pkg.sv */
// spsc_pkg: register map, field layout, reset values and carriers for the
// soft pin section-two and reference-scale register block.
// assumes a 32-bit ahb-lite bus with word-aligned single transfers.
package spsc_pkg;
    // register indices (printed offsets are not multiples of four: byte address is index * 4)
    localparam logic [11:0] SPSC_IDX_INSEL   = 12'hC01;  // input frequency selection index
    localparam logic [11:0] SPSC_IDX_SYSREF  = 12'hC02;  // system pll preset index
    localparam logic [11:0] SPSC_IDX_SEC2EN  = 12'hC03;  // section-two enable index
    localparam logic [11:0] SPSC_IDX_SCALE   = 12'hC04;  // reference scale index
    localparam logic [11:0] SPSC_IDX_LOAD    = 12'hC07;  // rom load strobe index
    localparam logic [11:0] SPSC_IDX_STATUS  = 12'hC10;  // applied-settings status index
    localparam int          SPSC_AW          = 14;       // byte address width used
    // field positions
    localparam int          SPSC_SCALE_B_LO  = 2;        // second reference scale [3:2]
    localparam int          SPSC_SCALE_A_LO  = 0;        // first reference scale [1:0]
    localparam int          SPSC_SEC2EN_BIT  = 0;        // section-two enable bit
    localparam int          SPSC_LOAD_BIT    = 0;        // load-from-rom bit
    // reset values
    localparam logic [7:0]  SPSC_RST_BYTE    = 8'h00;    // all writable fields reset to zero
    // scale codes
    localparam logic [1:0]  SPSC_DIV1        = 2'h0;     // divide by 1
    localparam logic [1:0]  SPSC_DIV4        = 2'h1;     // divide by 4
    localparam logic [1:0]  SPSC_DIV8        = 2'h2;     // divide by 8
    localparam logic [1:0]  SPSC_DIV16       = 2'h3;     // divide by 16
    // ahb-lite encodings
    localparam logic [1:0]  SPSC_HTRANS_NSEQ = 2'h2;     // nonsequential
    localparam logic [1:0]  SPSC_HTRANS_SEQ  = 2'h3;     // sequential
    localparam logic [2:0]  SPSC_HSIZE_WORD  = 3'h2;     // 32-bit transfer

    // system pll source kind
    typedef enum logic {
        SPSC_SRC_CRYSTAL = 1'b0,                         // crystal resonator source
        SPSC_SRC_OSC     = 1'b1                          // crystal oscillator source
    } spsc_src_type;

    // decoded system pll preset carrier
    typedef struct packed {
        spsc_src_type src;                               // crystal or oscillator
        logic         freq_49m;                          // 1: 49.152 mhz, 0: 24.576 mhz
        logic         doubler_on;                        // input doubler
        logic [5:0]   fb_n;                              // feedback divider n
    } spsc_syspll_type;

    // applied reference configuration carrier
    typedef struct packed {
        logic [3:0]   in_sel;                            // predefined input frequency code
        logic [4:0]   ratio_a;                           // first reference divide ratio
        logic [4:0]   ratio_b;                           // second reference divide ratio
        logic         sec2_active;                       // section two in force
    } spsc_refcfg_type;

    // state of the bus slave
    typedef struct packed {
        logic                     act;                   // data phase pending
        logic                     wr;                    // pending access is write
        logic [SPSC_AW-1:0]       addr;                  // latched address
    } spsc_ahb_type;
endpackage

/* rtl/spsc_syspll_decode.sv */
// spsc_syspll_decode: maps the two-bit system pll preset code to settings.
// assumes a plain combinational use by the register block.
module spsc_syspll_decode (
    input  wire logic [1:0]                code,     // preset code
    output spsc_pkg::spsc_syspll_type      cfg       // decoded settings
);
    import spsc_pkg::*;
    // lookup of the four presets
    always_comb begin
        unique case (code)
            2'h0:    cfg = '{SPSC_SRC_CRYSTAL, 1'b0, 1'b1, 6'h10};
            2'h1:    cfg = '{SPSC_SRC_CRYSTAL, 1'b1, 1'b1, 6'h08};
            2'h2:    cfg = '{SPSC_SRC_OSC,     1'b0, 1'b0, 6'h20};
            2'h3:    cfg = '{SPSC_SRC_OSC,     1'b1, 1'b0, 6'h10};
        endcase
    end
endmodule

/* rtl/spsc_scale_decode.sv */
// spsc_scale_decode: turns a two-bit reference scale code into a divide ratio.
// assumes the caller gates the ratio by section-two enable.
module spsc_scale_decode (
    input  wire logic [1:0]  code,     // scale code
    output logic      [4:0]  ratio     // divide ratio 1, 4, 8 or 16
);
    import spsc_pkg::*;
    // code to ratio
    always_comb begin
        unique case (code)
            SPSC_DIV1:  ratio = 5'h01;
            SPSC_DIV4:  ratio = 5'h04;
            SPSC_DIV8:  ratio = 5'h08;
            SPSC_DIV16: ratio = 5'h10;
        endcase
    end
endmodule

/* rtl/spsc_regs.sv */
// spsc_regs: ahb-lite register block for the soft pin program section two,
// input selection, system pll preset and per-reference input scaling.
// assumes a single ahb-lite master, word transfers, one clock, async reset pin.
//
// Notes on behaviour
// - codes 10, 11: oscillator presets, doubler off
// - enable clear: section-two scale contents ignored
// - enable set: section two applies if pin-program
// - second reference scale: divide 1/4/8/16
// - first reference scale resets to divide 1
// - selection picks one of 16; rom reload
// - codes 00, 01: crystal presets, doubler on
//
// Implementation choice: register access over AHB-Lite.
module spsc_regs (
    input  wire logic                   ref_clk,         // 200 mhz clock
    input  wire logic                   arst_n,          // async reset, active low
    input  wire logic                   pin_prog_pin,    // pin_program_select_pin, async
    input  wire logic                   hsel,            // slave select
    input  wire logic [31:0]            haddr,           // byte address
    input  wire logic [1:0]             htrans,          // transfer type
    input  wire logic                   hwrite,          // write when high
    input  wire logic [2:0]             hsize,           // transfer size
    input  wire logic [31:0]            hwdata,          // write data
    input  wire logic                   hready,          // bus ready in
    output logic      [31:0]            hrdata,          // read data
    output logic                        hreadyout,       // slave ready
    output logic                        hresp,           // always okay
    output spsc_pkg::spsc_syspll_type   syspll_cfg,      // applied system pll settings
    output spsc_pkg::spsc_refcfg_type   ref_cfg,         // applied reference settings
    output logic                        rom_load         // one-cycle rom reload pulse
);
    import spsc_pkg::*;

    // module state apart from the reset release pair
    typedef struct packed {
        logic [1:0]       pin_sync;     // pin synchroniser pair
        spsc_ahb_type     ahb;          // bus slave state
        logic [31:0]      rdata;        // read data register
        logic [3:0]       in_sel;       // input frequency selection
        logic [1:0]       sys_code;     // system pll preset code
        logic             sec2_en;      // section-two enable
        logic [3:0]       scale;        // raw scale register [3:0]
        spsc_syspll_type  syspll;       // applied pll settings
        spsc_refcfg_type  refcfg;       // applied reference settings
        logic             load;         // load pulse
    } spsc_state_type;

    spsc_state_type   st_q;             // registered state
    spsc_state_type   st_d;             // next state
    spsc_syspll_type  pll_dec;          // decoded preset
    logic [4:0]       ratio_a;          // decoded first ratio
    logic [4:0]       ratio_b;          // decoded second ratio
    logic [1:0]       rst_sync_q;       // reset release pair
    logic             rst_n;            // synchronised reset
    logic             sec2_on;          // section two in force
    logic             take;             // address phase accepted
    logic [11:0]      widx;             // register index of data phase

    // reset release through two flops, constant on assert
    // kept apart from the state struct: only these flops are reset by the pin itself,
    // and one struct written from two processes would have two drivers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // preset and scale lookups
    spsc_syspll_decode u_pll (
        .code (st_q.sys_code),
        .cfg  (pll_dec)
    );
    spsc_scale_decode u_scale_a (
        .code (st_q.scale[SPSC_SCALE_A_LO +: 2]),
        .ratio(ratio_a)
    );
    spsc_scale_decode u_scale_b (
        .code (st_q.scale[SPSC_SCALE_B_LO +: 2]),
        .ratio(ratio_b)
    );

    assign sec2_on = st_q.sec2_en & st_q.pin_sync[1];
    assign take    = hsel & hready & (htrans == SPSC_HTRANS_NSEQ || htrans == SPSC_HTRANS_SEQ);
    assign widx    = 12'(st_q.ahb.addr[SPSC_AW-1:2]);

    // next-state logic
    always_comb begin
        st_d          = st_q;
        st_d.pin_sync = {st_q.pin_sync[0], pin_prog_pin};
        st_d.load     = 1'b0;
        // data phase: write of the latched register; reads were decoded in the address phase
        if (st_q.ahb.act) begin
            if (st_q.ahb.wr) begin
                unique case (widx)
                    SPSC_IDX_INSEL:  st_d.in_sel   = hwdata[3:0];
                    SPSC_IDX_SYSREF: st_d.sys_code = hwdata[1:0];
                    SPSC_IDX_SEC2EN: st_d.sec2_en  = hwdata[SPSC_SEC2EN_BIT];
                    SPSC_IDX_SCALE:  st_d.scale    = hwdata[3:0];
                    SPSC_IDX_LOAD:   st_d.load     = hwdata[SPSC_LOAD_BIT];
                    default: ;                                                   // unmapped: dropped
                endcase
            end
        end
        // address phase capture
        if (take) begin
            st_d.ahb.act  = 1'b1;
            st_d.ahb.wr   = hwrite;
            st_d.ahb.addr = haddr[SPSC_AW-1:0];
            // read data prepared now so it stands in the data phase
            st_d.rdata = 32'h0;
            if (!hwrite) begin
                unique case (12'(haddr[SPSC_AW-1:2]))
                    // next-state copies: a read right behind a write sees the new value
                    SPSC_IDX_INSEL:  st_d.rdata = {28'h0, st_d.in_sel};
                    SPSC_IDX_SYSREF: st_d.rdata = {30'h0, st_d.sys_code};
                    SPSC_IDX_SEC2EN: st_d.rdata = {31'h0, st_d.sec2_en};
                    SPSC_IDX_SCALE:  st_d.rdata = {28'h0, st_d.scale};
                    SPSC_IDX_STATUS: st_d.rdata = {17'h0, st_q.refcfg};
                    default:         st_d.rdata = 32'h0;                         // unmapped reads zero
                endcase
            end
        end else if (hready) begin
            st_d.ahb.act = 1'b0;
        end
        // rom reload applies selection and preset
        if (st_q.load) begin
            st_d.syspll        = pll_dec;
            st_d.refcfg.in_sel = st_q.in_sel;
        end
        // scaling follows section-two gating continuously
        st_d.refcfg.sec2_active = sec2_on;
        st_d.refcfg.ratio_a = sec2_on ? ratio_a : 5'h01;
        st_d.refcfg.ratio_b = sec2_on ? ratio_b : 5'h01;
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.pin_sync <= 2'h0;
            st_q.ahb      <= '0;
            st_q.rdata    <= 32'h0;
            st_q.in_sel   <= 4'h0;
            st_q.sys_code <= 2'h0;
            st_q.sec2_en  <= 1'b0;
            st_q.scale    <= 4'h0;
            st_q.syspll   <= '{SPSC_SRC_CRYSTAL, 1'b0, 1'b1, 6'h10};
            st_q.refcfg   <= '{4'h0, 5'h01, 5'h01, 1'b0};
            st_q.load     <= 1'b0;
        end else begin
            st_q.pin_sync <= st_d.pin_sync;
            st_q.ahb      <= st_d.ahb;
            st_q.rdata    <= st_d.rdata;
            st_q.in_sel   <= st_d.in_sel;
            st_q.sys_code <= st_d.sys_code;
            st_q.sec2_en  <= st_d.sec2_en;
            st_q.scale    <= st_d.scale;
            st_q.syspll   <= st_d.syspll;
            st_q.refcfg   <= st_d.refcfg;
            st_q.load     <= st_d.load;
        end
    end

    // outputs straight from flops; slave is always ready and okay
    assign hrdata     = st_q.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign syspll_cfg = st_q.syspll;
    assign ref_cfg    = st_q.refcfg;
    assign rom_load   = st_q.load;
endmodule

/* bench/spsc_regs_asserts.sv */
// spsc_regs_asserts: port-level checker for the section-two and scale register block.
// assumes it is bound onto spsc_regs, one clock, active-low async reset.
module spsc_regs_asserts import spsc_pkg::*; (
    input wire logic                      ref_clk,      // clock
    input wire logic                      arst_n,       // async reset, active low
    input wire logic                      pin_prog_pin, // pin-program select
    input wire logic                      hreadyout,    // slave ready
    input wire logic                      hresp,        // response
    input wire spsc_pkg::spsc_syspll_type syspll_cfg,   // applied pll preset
    input wire spsc_pkg::spsc_refcfg_type ref_cfg,      // applied reference config
    input wire logic                      rom_load      // reload strobe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // pin held low long enough to pass the sync flops
    sequence pin_low_run; !pin_prog_pin [*5]; endsequence
    // strobe lasts a single cycle
    sequence load_pulse; rom_load ##1 !rom_load; endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    a_osc_preset: assert property (syspll_cfg.src == SPSC_SRC_OSC |->
        !syspll_cfg.doubler_on && syspll_cfg.fb_n == (syspll_cfg.freq_49m ? 6'h10 : 6'h20))
        else $error("oscillator preset settings wrong");
    a_crystal_resonator_source_preset: assert property (syspll_cfg.src == SPSC_SRC_CRYSTAL |->
        syspll_cfg.doubler_on && syspll_cfg.fb_n == (syspll_cfg.freq_49m ? 6'h08 : 6'h10))
        else $error("crystal preset settings wrong");
    a_sec2_off: assert property (!ref_cfg.sec2_active |-> ref_cfg.ratio_a == 5'h01 && ref_cfg.ratio_b == 5'h01)
        else $error("scale applied while section two off");
    a_pin_gate: assert property (pin_low_run |-> !ref_cfg.sec2_active)
        else $error("section two active with pin low");
    a_ratio_b_set: assert property (ref_cfg.ratio_b inside {5'h01, 5'h04, 5'h08, 5'h10})
        else $error("second reference ratio illegal");
    a_ratio_a_set: assert property (ref_cfg.ratio_a inside {5'h01, 5'h04, 5'h08, 5'h10})
        else $error("first reference ratio illegal");
    a_load_once: assert property (rom_load |-> load_pulse)
        else $error("reload strobe longer than one cycle");
    a_preset_hold: assert property (!$past(rom_load) |-> $stable(syspll_cfg) && $stable(ref_cfg.in_sel))
        else $error("preset or selection changed without reload");
endmodule
bind spsc_regs spsc_regs_asserts u_asserts (.ref_clk, .arst_n, .pin_prog_pin, .hreadyout, .hresp,
    .syspll_cfg, .ref_cfg, .rom_load);

/* bench/soft_pin_section2_scaling_test.sv */
// soft_pin_section2_scaling_test: self-checking bench for the spsc_regs block.
// assumes zero-wait ahb-lite answers and reset release through two flops.
module soft_pin_section2_scaling_test import spsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic            ref_clk, arst_n, pin_prog_pin, hsel, hwrite, hready; // bench drives
    logic [31:0]     haddr, hwdata, hrdata, rd;                       // bus data
    logic [1:0]      htrans;                                          // transfer type
    logic            hreadyout, hresp, rom_load, en;                  // outputs, scratch
    logic [3:0]      sc;                                              // scale code pair
    logic [1:0]      pc;                                              // preset code in force
    logic [3:0]      si;                                              // selection in force
    spsc_syspll_type syspll_cfg;                                      // pll preset seen
    spsc_refcfg_type ref_cfg;                                         // reference config seen
    int              failures, comparisons;                           // tallies
    int              seed = int'(32'hD43D4C8B);                       // fixed seed
    assign hready = hreadyout;
    spsc_regs DUT (.ref_clk, .arst_n, .pin_prog_pin, .hsel, .haddr, .htrans, .hwrite,
        .hsize(SPSC_HSIZE_WORD), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .syspll_cfg, .ref_cfg, .rom_load);
    // 200 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // compare and tally
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic complete_run;
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // single transfer: address phase, then data phase
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= SPSC_HTRANS_NSEQ;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    // byte address of a register index
    function automatic logic [31:0] adr(input logic [11:0] idx);
        return {18'h00000, idx, 2'h0};
    endfunction
    // expected preset for a code
    function automatic logic [8:0] pll(input logic [1:0] c);
        return c[1] ? {SPSC_SRC_OSC, c[0], 1'b0, (c[0] ? 6'h10 : 6'h20)}
                    : {SPSC_SRC_CRYSTAL, c[0], 1'b1, (c[0] ? 6'h08 : 6'h10)};
    endfunction
    // expected divide ratio
    function automatic logic [4:0] ratio(input logic [1:0] c, input logic on);
        return (on && c != 2'h0) ? 5'h01 << ({1'b0, c} + 3'h1) : 5'h01;
    endfunction
    // hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        complete_run;
    end
    // main sequence
    initial begin
        {hsel, hwrite, pin_prog_pin, arst_n} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(syspll_cfg, pll(2'h0));
        check(ref_cfg, {4'h0, 5'h01, 5'h01, 1'b0});
        check(rom_load, 1'b0);
        xfer(adr(SPSC_IDX_SCALE), 1'b0, 32'h0);
        check(rd, 32'h0);
        xfer(32'h00003FF8, 1'b0, 32'h0);
        check(rd, 32'h0);
        pc = 2'h0;
        // every preset code, reversed, with a random selection
        for (int c = 3; c >= 0; c--) begin
            sc = 4'($random(seed));
            xfer(adr(SPSC_IDX_INSEL), 1'b1, {28'h0, sc});
            xfer(adr(SPSC_IDX_SYSREF), 1'b1, 32'(c));
            repeat (2) @(posedge ref_clk);
            check(syspll_cfg, pll(pc));
            xfer(adr(SPSC_IDX_LOAD), 1'b1, 32'h1);
            @(posedge ref_clk);
            check(rom_load, 1'b1);
            repeat (3) @(posedge ref_clk);
            check(rom_load, 1'b0);
            check(syspll_cfg, pll(2'(c)));
            check(ref_cfg.in_sel, sc);
            pc = 2'(c);
        end
        si = sc;
        // all scale codes, enable off then on, pin random then both levels
        for (int i = 0; i < 32; i++) begin
            en = i[4];
            sc = i[3:0];
            pin_prog_pin <= (i < 24) ? 1'($random(seed)) : i[0];
            xfer(adr(SPSC_IDX_SEC2EN), 1'b1, {$random(seed)} & 32'hFFFFFFFE | 32'(en));
            xfer(adr(SPSC_IDX_SCALE), 1'b1, {$random(seed)} & 32'hFFFFFFF0 | 32'(sc));
            repeat (5) @(posedge ref_clk);
            check(ref_cfg.ratio_a, ratio(sc[1:0], en & pin_prog_pin));
            check(ref_cfg.ratio_b, ratio(sc[3:2], en & pin_prog_pin));
            check(ref_cfg.sec2_active, en & pin_prog_pin);
            xfer(adr(SPSC_IDX_SCALE), 1'b0, 32'h0);
            check(rd[3:0], sc);
        end
        // applied settings read back: last pass had enable and pin high, both codes 11
        xfer(adr(SPSC_IDX_STATUS), 1'b0, 32'h0);
        check(rd, {17'h0, si, 5'h10, 5'h10, 1'b1});
        // reset in mid-run brings the scale back to divide by one
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check(ref_cfg, {4'h0, 5'h01, 5'h01, 1'b0});
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        xfer(adr(SPSC_IDX_SCALE), 1'b0, 32'h0);
        check(rd[3:0], 4'h0);
        complete_run;
    end
endmodule
